// ==== inc/barb_pkg.sv ====
// constants shared by both ends of the battery front end register link
package barb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 9;
	localparam logic [7:0] ADDR_CFG_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FAULT_STATUS = 8'h01;
	localparam logic [7:0] ADDR_BALANCE = 8'h02;
	localparam logic [7:0] ADDR_MONITOR_SEL = 8'h03;
	localparam logic [7:0] ADDR_POWER_SW = 8'h04;
	localparam logic [7:0] ADDR_DISCH_CFG = 8'h05;
	localparam logic [7:0] ADDR_CHG_CFG = 8'h06;
	localparam logic [7:0] ADDR_FEATURE = 8'h07;
	localparam logic [7:0] ADDR_UNLOCK = 8'h08;
	localparam logic [7:0] ADDR_LAST = 8'h08;
	// writable bit masks and the read-only fault flag mask, reserved positions excluded
	localparam logic [7:0] MASK_BALANCE = 8'hfe;
	localparam logic [7:0] MASK_MONITOR_SEL = 8'hcf;
	localparam logic [7:0] MASK_POWER_SW = 8'hc3;
	localparam logic [7:0] MASK_UNLOCK = 8'hf8;
	localparam logic [7:0] MASK_FAULT = 8'h3f;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// config/status bits
	localparam int BIT_SINGLE_FE = 5;
	localparam int BIT_WAKE_STATE = 4;
	// fault bits
	localparam int BIT_EXT_OT = 5;
	localparam int BIT_INT_OT = 4;
	localparam int BIT_LOAD_FAULT = 3;
	localparam int BIT_DSC_SHORT = 2;
	localparam int BIT_DSC_OC = 1;
	localparam int BIT_CHG_OC = 0;
	// power switch bits
	localparam int BIT_FORCE_SLEEP = 7;
	localparam int BIT_LOAD_MON = 6;
	localparam int BIT_CHG_SW = 1;
	localparam int BIT_DSC_SW = 0;
	// discharge cfg
	localparam int BIT_DSC_OC_AUTO_OFF = 7;
	localparam int BIT_SHORT_AUTO_OFF = 4;
	// charge cfg
	localparam int BIT_CHG_OC_AUTO_OFF = 7;
	// feature bits
	localparam int BIT_TEMP_SCAN_DIS = 7;
	localparam int BIT_REG_DIS = 6;
	localparam int BIT_TEMP_SUPPLY = 5;
	localparam int BIT_EXT_TRIP_DIS = 4;
	localparam int BIT_INT_TRIP_DIS = 3;
	localparam int BIT_FORCE_POR = 2;
	localparam int BIT_WAKE_DIS = 1;
	localparam int BIT_WAKE_POL = 0;
	// unlock bits
	localparam int BIT_FEATURE_UNLOCK = 7;
	localparam int BIT_CHG_UNLOCK = 6;
	localparam int BIT_DSC_UNLOCK = 5;
	// serial link timing: half bit period counted in system clock cycles
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int LINK_BIT_HZ = 100_000;
	localparam int LINK_HALF_CYCLES = SYS_CLK_HZ / (2 * LINK_BIT_HZ);
	localparam int HOST_CNT_W = 16;
	localparam logic HOST_WRITE = 1'b0;
	localparam logic HOST_READ = 1'b1;
endpackage

// ==== inc/barb_link_if.sv ====
// byte-serial link between the host controller and the front end register bank
`timescale 1ns/1ps
interface barb_link_if;
	logic sclk;
	logic sdat_host_o;
	logic sdat_host_oe;
	logic sdat_dev_o;
	logic sdat_dev_oe;
	logic sdat_line;

	// open-drain wire with pull-up: any enabled low driver pulls it low
	assign sdat_line = !((sdat_host_oe && !sdat_host_o) || (sdat_dev_oe && !sdat_dev_o));

	modport host
	(
		output sclk,
		output sdat_host_o,
		output sdat_host_oe,
		input sdat_line
	);
	modport dev
	(
		input sclk,
		output sdat_dev_o,
		output sdat_dev_oe,
		input sdat_line
	);
endinterface

// ==== rtl/barb_shift8.sv ====
// eight-bit shift register shared by both ends for serialising link bytes
`timescale 1ns/1ps
module barb_shift8 #(
	parameter int WIDTH = 8
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic shift,
	input wire logic shift_in,
	output logic [WIDTH-1:0] value
);
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			value <= '0;
		else if (load)
			value <= load_data;
		else if (shift)
			value <= {value[WIDTH-2:0], shift_in};
	end
endmodule

// ==== rtl/barb_device.sv ====
// front end register bank, slave end of the serial link
`timescale 1ns/1ps
// Behaviour
// - host never writes addresses above 08h
// - written one bit performs its action
// - status bit one while condition present
// - host writes reserved bits as zero (host masks only 02h, 03h, 04h and 08h; writes to 00h and 01h pass all bits)
// - host ignores reserved bits on read (host returns all eight read bits unmasked)
// - fault flags clear on read once gone
// - wake status follows live condition
// - sleep cleared at power-up and wake
// - host writing zero clears sleep
// - automatic trip clears switch bits
// - switch bits drive outputs, read commanded
// - discharge cfg writable only when unlocked
// - charge cfg writable only when unlocked
// - feature cfg writable only when unlocked
// - discharge cfg field layout
// - charge cfg field layout
// - scan stop, por, wake disable, polarity
// - thermal trip disables per source
// - regulator off and sensor supply bits
// - switch, sleep and load monitor bits
// - hardware sets each fault flag
// - hardware keeps wake status
module barb_device
(
	input wire logic sys_clk,
	input wire logic resetn,
	barb_link_if.dev link,
	input wire logic wake_pin,
	input wire logic chg_oc_event,
	input wire logic dsc_oc_event,
	input wire logic dsc_short_event,
	input wire logic load_fault_event,
	input wire logic int_ot_event,
	input wire logic ext_ot_event,
	output logic charge_switch_on,
	output logic discharge_switch_on,
	output logic force_sleep,
	output logic load_monitor_connect,
	output logic [7:0] balance_switch_enable,
	output logic [7:0] monitor_output_select,
	output logic [7:0] discharge_protect_cfg,
	output logic [7:0] charge_protect_cfg,
	output logic [7:0] feature_cfg,
	output logic force_por
);
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RW, D_WDATA, D_RDATA} barb_dstate_e;
	barb_dstate_e state_reg;
	logic sclk_d_reg;
	logic sdat_d_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] addr_reg;
	logic [7:0] device_config_status_reg;
	logic [7:0] fault_status_reg;
	logic [7:0] write_unlock_reg;
	logic [7:0] shift_val;
	logic [7:0] read_data;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_start;
	logic byte_done;
	logic write_strobe;
	logic read_strobe;
	logic [5:0] fault_live;
	logic wake_active;
	logic auto_trip;
	logic rd_done_reg;

	// link framing: sclk idles high; data falling while sclk high opens a frame
	assign sclk_rise = link.sclk && !sclk_d_reg;
	assign sclk_fall = !link.sclk && sclk_d_reg;
	assign frame_start = link.sclk && sclk_d_reg && sdat_d_reg && !link.sdat_line;
	assign byte_done = sclk_rise && (bit_cnt_reg == 4'd7);
	assign write_strobe = (state_reg == D_WDATA) && byte_done;
	assign read_strobe = rd_done_reg && frame_start;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_d_reg <= 1'b1;
			sdat_d_reg <= 1'b1;
		end
		else
		begin
			sclk_d_reg <= link.sclk;
			sdat_d_reg <= link.sdat_line;
		end
	end

	barb_shift8 u_rx
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.load(frame_start),
		.load_data(barb_pkg::RESET_VALUE),
		.shift(sclk_rise),
		.shift_in(link.sdat_line),
		.value(shift_val)
	);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= D_IDLE;
			bit_cnt_reg <= '0;
			addr_reg <= '0;
			rd_done_reg <= 1'b0;
		end
		else if (frame_start)
		begin
			rd_done_reg <= 1'b0;
			state_reg <= D_ADDR;
			bit_cnt_reg <= '0;
		end
		else if (sclk_rise)
		begin
			unique case (state_reg)
				D_IDLE:
					bit_cnt_reg <= '0;
				D_ADDR:
					if (bit_cnt_reg == 4'd7)
					begin
						addr_reg <= {shift_val[6:0], link.sdat_line};
						state_reg <= D_RW;
						bit_cnt_reg <= '0;
					end
					else
						bit_cnt_reg <= bit_cnt_reg + 4'd1;
				D_RW:
				begin
					state_reg <= (link.sdat_line == barb_pkg::HOST_READ) ? D_RDATA : D_WDATA;
					bit_cnt_reg <= '0;
				end
				D_WDATA, D_RDATA:
					if (bit_cnt_reg == 4'd7)
					begin
						rd_done_reg <= state_reg == D_RDATA;
						state_reg <= D_IDLE;
						bit_cnt_reg <= '0;
					end
					else
						bit_cnt_reg <= bit_cnt_reg + 4'd1;
			endcase
		end
	end

	// read mux; reserved bits read zero, unmapped addresses read zero
	always_comb
	begin
		unique case (addr_reg)
			barb_pkg::ADDR_CFG_STATUS: read_data = device_config_status_reg;
			barb_pkg::ADDR_FAULT_STATUS: read_data = fault_status_reg;
			barb_pkg::ADDR_BALANCE: read_data = balance_switch_enable;
			barb_pkg::ADDR_MONITOR_SEL: read_data = monitor_output_select;
			barb_pkg::ADDR_POWER_SW: read_data = {force_sleep, load_monitor_connect, 4'h0,
				charge_switch_on, discharge_switch_on};
			barb_pkg::ADDR_DISCH_CFG: read_data = discharge_protect_cfg;
			barb_pkg::ADDR_CHG_CFG: read_data = charge_protect_cfg;
			barb_pkg::ADDR_FEATURE: read_data = feature_cfg;
			barb_pkg::ADDR_UNLOCK: read_data = write_unlock_reg;
			default: read_data = barb_pkg::RESET_VALUE;
		endcase
	end

	// device drives data during read phase, changing on sclk fall; the last bit is
	// held until sclk falls so the line never moves while sclk is high
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			link.sdat_dev_o <= 1'b1;
			link.sdat_dev_oe <= 1'b0;
		end
		else if (state_reg == D_RDATA && sclk_fall)
		begin
			link.sdat_dev_oe <= 1'b1;
			link.sdat_dev_o <= read_data[3'(7 - bit_cnt_reg)];
		end
		else if (state_reg != D_RDATA && sclk_fall)
		begin
			link.sdat_dev_oe <= 1'b0;
			link.sdat_dev_o <= 1'b1;
		end
	end

	// status and fault tracking
	assign wake_active = !feature_cfg[barb_pkg::BIT_WAKE_DIS] &&
		(wake_pin == feature_cfg[barb_pkg::BIT_WAKE_POL]);
	assign fault_live = {ext_ot_event, int_ot_event, load_fault_event,
		dsc_short_event, dsc_oc_event, chg_oc_event};

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			device_config_status_reg <= barb_pkg::RESET_VALUE;
		else
		begin
			device_config_status_reg <= barb_pkg::RESET_VALUE;
			device_config_status_reg[barb_pkg::BIT_SINGLE_FE] <= 1'b1;
			device_config_status_reg[barb_pkg::BIT_WAKE_STATE] <= wake_active;
		end
	end

	// set wins over clear-on-read; a live condition keeps its flag
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			fault_status_reg <= barb_pkg::RESET_VALUE;
		else if (read_strobe && addr_reg == barb_pkg::ADDR_FAULT_STATUS)
			fault_status_reg <= {2'b00, fault_live};
		else
			fault_status_reg <= fault_status_reg | {2'b00, fault_live};
	end

	// automatic trip from any source but load fault turns both switches off unless that source is disabled
	assign auto_trip =
		(chg_oc_event && !charge_protect_cfg[barb_pkg::BIT_CHG_OC_AUTO_OFF]) ||
		(dsc_oc_event && !discharge_protect_cfg[barb_pkg::BIT_DSC_OC_AUTO_OFF]) ||
		(dsc_short_event && !discharge_protect_cfg[barb_pkg::BIT_SHORT_AUTO_OFF]) ||
		(ext_ot_event && !feature_cfg[barb_pkg::BIT_EXT_TRIP_DIS]) ||
		(int_ot_event && !feature_cfg[barb_pkg::BIT_INT_TRIP_DIS]);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			charge_switch_on <= 1'b0;
			discharge_switch_on <= 1'b0;
			load_monitor_connect <= 1'b0;
		end
		else if (auto_trip)
		begin
			charge_switch_on <= 1'b0;
			discharge_switch_on <= 1'b0;
		end
		else if (write_strobe && addr_reg == barb_pkg::ADDR_POWER_SW)
		begin
			charge_switch_on <= shift_val[barb_pkg::BIT_CHG_SW - 1];
			discharge_switch_on <= link.sdat_line;
			load_monitor_connect <= shift_val[barb_pkg::BIT_LOAD_MON - 1];
		end
	end

	// sleep: wake level or a zero write clears it; wake wins over a set
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			force_sleep <= 1'b0;
		else if (wake_active)
			force_sleep <= 1'b0;
		else if (write_strobe && addr_reg == barb_pkg::ADDR_POWER_SW)
			force_sleep <= shift_val[barb_pkg::BIT_FORCE_SLEEP - 1];
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			balance_switch_enable <= barb_pkg::RESET_VALUE;
			monitor_output_select <= barb_pkg::RESET_VALUE;
			write_unlock_reg <= barb_pkg::RESET_VALUE;
			discharge_protect_cfg <= barb_pkg::RESET_VALUE;
			charge_protect_cfg <= barb_pkg::RESET_VALUE;
			feature_cfg <= barb_pkg::RESET_VALUE;
		end
		else if (write_strobe)
		begin
			unique case (addr_reg)
				barb_pkg::ADDR_BALANCE:
					balance_switch_enable <= {shift_val[6:0], link.sdat_line} &
						barb_pkg::MASK_BALANCE;
				barb_pkg::ADDR_MONITOR_SEL:
					monitor_output_select <= {shift_val[6:0], link.sdat_line} &
						barb_pkg::MASK_MONITOR_SEL;
				barb_pkg::ADDR_UNLOCK:
					write_unlock_reg <= {shift_val[6:0], link.sdat_line} &
						barb_pkg::MASK_UNLOCK;
				barb_pkg::ADDR_DISCH_CFG:
					if (write_unlock_reg[barb_pkg::BIT_DSC_UNLOCK])
						discharge_protect_cfg <= {shift_val[6:0], link.sdat_line};
				barb_pkg::ADDR_CHG_CFG:
					if (write_unlock_reg[barb_pkg::BIT_CHG_UNLOCK])
						charge_protect_cfg <= {shift_val[6:0], link.sdat_line};
				barb_pkg::ADDR_FEATURE:
					if (write_unlock_reg[barb_pkg::BIT_FEATURE_UNLOCK])
						feature_cfg <= {shift_val[6:0], link.sdat_line};
				default:
				begin
				end
			endcase
		end
	end

	// force power-on reset pulses for one cycle after the bit lands
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			force_por <= 1'b0;
		else
			force_por <= write_strobe && addr_reg == barb_pkg::ADDR_FEATURE &&
				write_unlock_reg[barb_pkg::BIT_FEATURE_UNLOCK] &&
				shift_val[barb_pkg::BIT_FORCE_POR - 1];
	end
endmodule

// ==== rtl/barb_host.sv ====
// host controller end: runs register read and write frames over the link
`timescale 1ns/1ps
module barb_host #(
	parameter int HALF_CYCLES = barb_pkg::LINK_HALF_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	barb_link_if.host link,
	input wire logic req_valid,
	input wire logic req_rw,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic req_refused
);
	typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_STOP} barb_hstate_e;
	barb_hstate_e state_reg;
	logic [15:0] tick_cnt_reg;
	logic tick;
	logic phase_reg;
	logic [4:0] bit_idx_reg;
	logic rw_reg;
	logic [7:0] tx_shift;
	logic [7:0] rx_shift;
	logic load_tx;
	logic shift_tx;
	logic capture;
	logic tx_bit;
	logic [7:0] req_wdata_reg;
	logic [7:0] addr_reg;
	logic [7:0] wmask;

	// half-bit enable from a divider on sys_clk
	assign tick = (tick_cnt_reg == 16'(HALF_CYCLES - 1));
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			tick_cnt_reg <= '0;
		else if (tick || state_reg == H_IDLE)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'd1;
	end

	// bits 0..7 address, bit 8 direction, bits 9..16 data
	assign load_tx = state_reg == H_IDLE && req_valid && req_addr <= barb_pkg::ADDR_LAST;
	assign shift_tx = state_reg == H_BITS && tick && phase_reg && bit_idx_reg != 5'd8;
	assign capture = state_reg == H_BITS && tick && !phase_reg && rw_reg && bit_idx_reg > 5'd8;
	assign tx_bit = bit_idx_reg == 5'd8 ? rw_reg : tx_shift[7];

	barb_shift8 u_tx
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.load(load_tx || (state_reg == H_BITS && tick && phase_reg && bit_idx_reg == 5'd8)),
		.load_data(load_tx ? req_addr : (req_wdata_reg & wmask)),
		.shift(shift_tx),
		.shift_in(1'b0),
		.value(tx_shift)
	);

	// reserved bits are forced to zero on writes to masked registers
	function automatic logic [7:0] mask_for(input logic [7:0] a);
		unique case (a)
			barb_pkg::ADDR_BALANCE: mask_for = barb_pkg::MASK_BALANCE;
			barb_pkg::ADDR_MONITOR_SEL: mask_for = barb_pkg::MASK_MONITOR_SEL;
			barb_pkg::ADDR_POWER_SW: mask_for = barb_pkg::MASK_POWER_SW;
			barb_pkg::ADDR_UNLOCK: mask_for = barb_pkg::MASK_UNLOCK;
			default: mask_for = 8'hff;
		endcase
	endfunction
	assign wmask = mask_for(addr_reg);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= H_IDLE;
			phase_reg <= 1'b0;
			bit_idx_reg <= '0;
			rw_reg <= 1'b0;
			addr_reg <= '0;
			req_wdata_reg <= '0;
			link.sclk <= 1'b1;
			link.sdat_host_o <= 1'b1;
			link.sdat_host_oe <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				H_IDLE:
					if (load_tx)
					begin
						rw_reg <= req_rw;
						addr_reg <= req_addr;
						req_wdata_reg <= req_wdata;
						link.sdat_host_oe <= 1'b1;
						link.sdat_host_o <= 1'b0;
						state_reg <= H_START;
					end
				H_START:
					if (tick)
					begin
						link.sclk <= 1'b0;
						phase_reg <= 1'b0;
						bit_idx_reg <= '0;
						state_reg <= H_BITS;
					end
				H_BITS:
					if (tick)
					begin
						phase_reg <= !phase_reg;
						if (!phase_reg)
						begin
							link.sclk <= 1'b1;
						end
						else if (bit_idx_reg == 5'd16)
						begin
							link.sclk <= 1'b0;
							state_reg <= H_STOP;
						end
						else
						begin
							link.sclk <= 1'b0;
							bit_idx_reg <= bit_idx_reg + 5'd1;
						end
					end
				// pull data low a cycle after the fall, on the same edge that the device lets go,
				// so the release with sclk high is always a visible stop
				H_STOP:
					if (!phase_reg)
					begin
						link.sdat_host_oe <= 1'b1;
						link.sdat_host_o <= 1'b0;
						if (tick)
						begin
							link.sclk <= 1'b1;
							phase_reg <= 1'b1;
						end
					end
					else if (tick)
					begin
						link.sdat_host_oe <= 1'b0;
						link.sdat_host_o <= 1'b1;
						state_reg <= H_IDLE;
					end
			endcase
			// data changes while sclk low; released on read data bits
			if (state_reg == H_START && tick)
			begin
				link.sdat_host_o <= tx_bit;
			end
			else if (state_reg == H_BITS && tick && phase_reg && bit_idx_reg != 5'd16)
			begin
				link.sdat_host_oe <= !(rw_reg && bit_idx_reg >= 5'd8);
				link.sdat_host_o <= bit_idx_reg == 5'd7 ? rw_reg :
					(bit_idx_reg == 5'd8 ? (req_wdata_reg[7] & wmask[7]) :
					(rw_reg && bit_idx_reg >= 5'd8 ? 1'b1 : tx_shift[6]));
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rx_shift <= '0;
		else if (capture)
			rx_shift <= {rx_shift[6:0], link.sdat_line};
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_refused <= 1'b0;
		end
		else
		begin
			req_ready <= state_reg == H_IDLE && !req_valid;
			req_refused <= state_reg == H_IDLE && req_valid && req_addr > barb_pkg::ADDR_LAST;
			rsp_valid <= state_reg == H_STOP && tick && phase_reg;
			if (state_reg == H_STOP && tick && phase_reg && rw_reg)
				rsp_rdata <= rx_shift;
		end
	end
endmodule

// ==== verification/barb_link_asserts.sv ====
// protocol checker for the serial link between host controller and front end
`timescale 1ns/1ps
module barb_link_asserts #(
	parameter int HALF_CYCLES = 4
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic sdat_host_o,
	input wire logic sdat_host_oe,
	input wire logic sdat_dev_o,
	input wire logic sdat_dev_oe,
	input wire logic sdat_line
);
	logic sclk_reg;
	logic line_reg;
	logic in_frame_reg;
	logic dir_reg;
	logic [4:0] rise_cnt_reg;
	logic [15:0] low_cnt_reg;
	logic start_ev;
	logic stop_ev;
	logic sclk_rise;

	default clocking dcb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	assign start_ev = sclk && sclk_reg && line_reg && !sdat_line;
	assign stop_ev = sclk && sclk_reg && !line_reg && sdat_line;
	assign sclk_rise = sclk && !sclk_reg;

	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
		begin
			sclk_reg <= 1'b1;
			line_reg <= 1'b1;
		end
		else
		begin
			sclk_reg <= sclk;
			line_reg <= sdat_line;
		end

	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			in_frame_reg <= 1'b0;
		else if (start_ev)
			in_frame_reg <= 1'b1;
		else if (stop_ev)
			in_frame_reg <= 1'b0;

	// saturating so a runaway clock cannot wrap back into the legal range
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			rise_cnt_reg <= 5'h00;
		else if (start_ev)
			rise_cnt_reg <= 5'h00;
		else if (sclk_rise && rise_cnt_reg != 5'h1f)
			rise_cnt_reg <= rise_cnt_reg + 5'h01;

	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			dir_reg <= 1'b0;
		else if (sclk_rise && rise_cnt_reg == 5'h08)
			dir_reg <= sdat_line;

	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			low_cnt_reg <= 16'h0000;
		else
			low_cnt_reg <= sclk ? 16'h0000 : low_cnt_reg + 16'h0001;

	sequence start_s;
		sclk && $past(sclk) && $fell(sdat_line);
	endsequence

	sequence first_low_s;
		sclk ##[1:8] !sclk;
	endsequence

	idle_after_reset_a: assert property ($rose(resetn) |-> sclk && !sdat_host_oe && !sdat_dev_oe)
		else $error("link not idle after reset");
	start_to_clock_a: assert property (start_s |-> first_low_s)
		else $error("clock did not start after start condition");
	start_outside_frame_a: assert property (start_s |-> !in_frame_reg)
		else $error("data fell while clock high inside a frame");
	low_phase_a: assert property (sclk_rise && in_frame_reg |-> low_cnt_reg == HALF_CYCLES)
		else $error("clock low phase has wrong length");
	data_setup_a: assert property ($rose(sclk) |-> $stable(sdat_line))
		else $error("data changed at the sampling clock edge");
	frame_bits_a: assert property (stop_ev |-> rise_cnt_reg inside {5'd17, 5'd18})
		else $error("frame closed with wrong bit count");
	bit_bound_a: assert property (in_frame_reg |-> rise_cnt_reg <= 5'd18)
		else $error("too many clock pulses in frame");
	idle_clock_a: assert property (!in_frame_reg |-> sclk)
		else $error("clock moved outside a frame");
	dev_window_a: assert property (sdat_dev_oe |->
			in_frame_reg && dir_reg == barb_pkg::HOST_READ && rise_cnt_reg >= 5'd9)
		else $error("device drove data outside read data phase");
	dev_on_fall_a: assert property ($rose(sdat_dev_oe) |-> !sclk)
		else $error("device began driving while clock high");
	host_quiet_a: assert property (sdat_dev_oe |-> !(sdat_host_oe && !sdat_host_o))
		else $error("host pulled data low while device drives");
	frame_seen_c: cover property (start_s);
endmodule

// ==== verification/tb.sv ====
// self-checking bench: host controller and front end joined over the serial link
`timescale 1ns/1ps
module tb;
	localparam int HALF = 4;
	logic sys_clk;
	logic resetn;
	logic wake_pin;
	logic [5:0] ev;
	logic req_valid;
	logic req_rw;
	logic [7:0] req_addr;
	logic [7:0] req_wdata;
	logic req_ready;
	logic rsp_valid;
	logic [7:0] rsp_rdata;
	logic req_refused;
	logic chg_sw, dsc_sw, sleep_o, ldmon, por_o;
	logic [7:0] bal_o, mon_o, dcfg_o, ccfg_o, feat_o;
	logic [7:0] q;
	logic [7:0] d;
	logic [7:0] fault_latch;
	logic clear_pend;
	int model [9];
	int fail_count;
	int compares;
	int por_cnt;

	barb_link_if link ();
	barb_host #(.HALF_CYCLES(HALF)) barb_host_i (.sys_clk(sys_clk), .resetn(resetn),
		.link(link), .req_valid(req_valid), .req_rw(req_rw), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .req_refused(req_refused));
	barb_device barb_device_i (.sys_clk(sys_clk), .resetn(resetn), .link(link),
		.wake_pin(wake_pin), .chg_oc_event(ev[0]), .dsc_oc_event(ev[1]),
		.dsc_short_event(ev[2]), .load_fault_event(ev[3]), .int_ot_event(ev[4]),
		.ext_ot_event(ev[5]), .charge_switch_on(chg_sw), .discharge_switch_on(dsc_sw),
		.force_sleep(sleep_o), .load_monitor_connect(ldmon), .balance_switch_enable(bal_o),
		.monitor_output_select(mon_o), .discharge_protect_cfg(dcfg_o),
		.charge_protect_cfg(ccfg_o), .feature_cfg(feat_o), .force_por(por_o));
	barb_link_asserts #(.HALF_CYCLES(HALF)) barb_link_asserts_i (.sys_clk(sys_clk),
		.resetn(resetn), .sclk(link.sclk), .sdat_host_o(link.sdat_host_o),
		.sdat_host_oe(link.sdat_host_oe), .sdat_dev_o(link.sdat_dev_o),
		.sdat_dev_oe(link.sdat_dev_oe), .sdat_line(link.sdat_line));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (por_o === 1'b1)
			por_cnt++;

	task automatic finish_test();
		$display("Comparisons: %0d, mismatches: %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// reserved positions are left out of every register read comparison
	function automatic logic [7:0] mask(input int a);
		case (a)
			0: return 8'h30;
			1: return barb_pkg::MASK_FAULT;
			2: return barb_pkg::MASK_BALANCE;
			3: return barb_pkg::MASK_MONITOR_SEL;
			4: return barb_pkg::MASK_POWER_SW;
			7: return 8'hfb;
			8: return barb_pkg::MASK_UNLOCK;
			default: return 8'hff;
		endcase
	endfunction

	function automatic logic wake_act();
		return (model[7][0] ? wake_pin : !wake_pin) && !model[7][1];
	endfunction

	task automatic chk_out();
		check({chg_sw, dsc_sw, sleep_o, ldmon, 4'h0},
			{model[4][1], model[4][0], model[4][7], model[4][6], 4'h0}, "switches");
		check(bal_o, model[2][7:0], "balance");
		check(mon_o, model[3][7:0], "monitor select");
		check(dcfg_o, model[5][7:0], "discharge cfg");
		check(ccfg_o, model[6][7:0], "charge cfg");
		check(feat_o & 8'hfb, model[7][7:0], "feature cfg");
	endtask

	// a pending clear-on-read reloads the flags from live levels as the frame opens
	task automatic xfer(input logic rw, input logic [7:0] a, input logic [7:0] wd);
		int n;
		if (clear_pend)
		begin
			fault_latch = {2'b00, ev};
			clear_pend = 1'b0;
		end
		@(posedge sys_clk);
		#2;
		req_valid = 1'b1;
		req_rw = rw;
		req_addr = a;
		req_wdata = wd;
		n = 0;
		@(posedge sys_clk);
		while (req_ready !== 1'b1 && n < 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		#2;
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 2000)
		begin
			@(posedge sys_clk);
			n++;
		end
		q = rsp_rdata;
		check({7'h00, n < 2000}, 8'h01, "transfer completion");
	endtask

	task automatic wr(input int a, input logic [7:0] wd);
		xfer(barb_pkg::HOST_WRITE, a[7:0], wd);
		if (!(a < 2 || (a > 4 && a < 8 && !model[8][a])))
			model[a] = wd & mask(a);
		if (wake_act())
			model[4] = model[4] & 8'h7f;
		chk_out();
	endtask

	task automatic rd(input int a);
		logic [7:0] exp;
		xfer(barb_pkg::HOST_READ, a[7:0], 8'h00);
		exp = (a == 0) ? {2'b00, 1'b1, wake_act(), 4'h0} : (a == 1) ? fault_latch : model[a][7:0];
		check(q & mask(a), exp & mask(a), "register read");
		if (a == 1)
			clear_pend = 1'b1;
	endtask

	task automatic set_in(input logic w, input logic [5:0] v);
		@(posedge sys_clk);
		#2;
		wake_pin = w;
		ev = v;
		fault_latch = fault_latch | {2'b00, v};
		if (wake_act())
			model[4] = model[4] & 8'h7f;
		if ((v[0] && !model[6][7]) || (v[1] && !model[5][7]) || (v[2] && !model[5][4])
				|| (v[4] && !model[7][3]) || (v[5] && !model[7][4]))
			model[4] = model[4] & 8'hfc;
		repeat (4) @(posedge sys_clk);
		chk_out();
	endtask

	initial
	begin
		#2_000_000;
		fail_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		finish_test();
	end

	initial
	begin
		resetn = 1'b0;
		wake_pin = 1'b1;
		ev = 6'h00;
		req_valid = 1'b0;
		req_rw = 1'b0;
		req_addr = 8'h00;
		req_wdata = 8'h00;
		fault_latch = 8'h00;
		clear_pend = 1'b0;
		fail_count = 0;
		compares = 0;
		por_cnt = 0;
		foreach (model[i])
			model[i] = 0;
		void'($urandom(8));
		repeat (12) @(posedge sys_clk);
		#2;
		resetn = 1'b1;
		repeat (2) @(posedge sys_clk);
		chk_out();
		for (int a = 0; a < 9; a++)
			rd(a);
		wr(0, 8'hff);
		wr(1, 8'hff);
		rd(0);
		rd(1);
		repeat (3)
			for (int a = 2; a < 5; a++)
			begin
				wr(a, $urandom & mask(a) & 8'h7f);
				rd(a);
			end
		for (int a = 5; a < 8; a++)
		begin
			wr(8, $urandom & 8'h18);
			wr(a, $urandom & 8'hf8);
			rd(a);
			wr(8, ($urandom & 8'h18) | (8'h01 << a));
			wr(a, $urandom & 8'hf8);
			rd(a);
		end
		wr(8, 8'he0);
		wr(7, 8'h00);
		wr(4, 8'h80);
		wr(4, 8'h00);
		wr(4, 8'h80);
		set_in(1'b0, 6'h00);
		rd(0);
		set_in(1'b1, 6'h00);
		rd(0);
		wr(7, 8'h01);
		rd(0);
		for (int p = 0; p < 2; p++)
		begin
			wr(5, (p ? 8'h90 : 8'h00) | ($urandom & 8'h6f));
			wr(6, (p ? 8'h80 : 8'h00) | ($urandom & 8'h7f));
			wr(7, p ? 8'h19 : 8'h01);
			for (int i = 0; i < 6; i++)
			begin
				wr(4, 8'h03);
				set_in(1'b1, 6'h01 << i);
				set_in(1'b1, 6'h00);
				rd(1);
				rd(1);
			end
		end
		set_in(1'b1, 6'h02);
		rd(1);
		rd(1);
		set_in(1'b1, 6'h00);
		rd(1);
		for (int k = 0; k < 3; k++)
		begin
			d = (k == 0) ? 8'h09 : (k == 1) ? 8'hff : 8'h0a + 8'($urandom % 245);
			@(posedge sys_clk);
			#2;
			req_valid = 1'b1;
			req_rw = barb_pkg::HOST_WRITE;
			req_addr = d;
			repeat (3) @(posedge sys_clk);
			check({7'h00, req_refused}, 8'h01, "reserved address refused");
			#2;
			req_valid = 1'b0;
		end
		rd(8);
		// forcing a power-on reset may clear the bank, so nothing is read back after it
		xfer(barb_pkg::HOST_WRITE, 8'h07, 8'h05);
		repeat (10) @(posedge sys_clk);
		check(por_cnt[7:0], 8'h01, "reset pulse count");
		finish_test();
	end
endmodule
